// ===== logic/gst_pkg.sv
// shared constants, register map and field layouts of the gated sixteen bit timer
package gst_pkg;
	// register indices on the plain register port
	localparam logic [3:0] ADDR_COUNT_LOW = 4'h0;
	localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
	localparam logic [3:0] ADDR_TIMER_CONTROL = 4'h2;
	localparam logic [3:0] ADDR_GATE_CONFIG = 4'h3;
	localparam logic [3:0] ADDR_PERIPHERAL_FLAGS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_ENABLES = 4'h5;
	localparam logic [3:0] ADDR_CC_LOW = 4'h6;
	localparam logic [3:0] ADDR_CC_HIGH = 4'h7;
	localparam logic [3:0] ADDR_CC_MODE = 4'h8;

	// reset values
	localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] GATE_CONFIG_RESET = 8'h00;
	localparam logic [7:0] IRQ_ENABLES_RESET = 8'h00;
	localparam logic [7:0] CC_MODE_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] CC_RESET = 16'h0000;

	// bit positions of the loose control bits
	localparam int FLAG_OVERFLOW_BIT = 0;
	localparam int EN_OVERFLOW_BIT = 0;
	localparam int EN_PERIPHERAL_BIT = 1;
	localparam int EN_GLOBAL_BIT = 2;
	localparam int CC_CAPTURE_BIT = 0;
	localparam int CC_COMPARE_BIT = 1;
	localparam int CC_SPECIAL_BIT = 2;

	// gate source codes
	localparam logic [1:0] GATE_SRC_PIN = 2'h0;
	localparam logic [1:0] GATE_SRC_ALT_PIN = 2'h1;
	localparam logic [1:0] GATE_SRC_COMPARATOR = 2'h2;

	// last count of the instruction clock divider; the system clock is divided by four
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
	localparam logic [15:0] IRQ_VECTOR = 16'h0004;

	typedef struct packed {
		logic gate_polarity;
		logic gate_enable;
		logic [1:0] prescale_select;
		logic lowpower_osc_enable;
		logic sync_bypass;
		logic clock_source_select;
		logic timer_on;
	} gst_control_t;

	typedef struct packed {
		logic [4:0] unused;
		logic alternate_clock_select;
		logic [1:0] gate_source_select;
	} gst_gate_config_t;

	// pins that arrive from outside the clock domain
	typedef struct packed {
		logic external_clock_pin;
		logic lowpower_osc_clock;
		logic gate_pin;
		logic gate_pin_alt;
		logic comparator_output;
		logic capture_event;
		logic sleep;
		logic internal_oscillator_no_clock_out_pin;
	} gst_pins_t;
endpackage

// ===== logic/gst_sync.sv
// two flip-flop synchroniser for a bundle of outside levels
`timescale 1ns/1ps
module gst_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	// first stage is read only by the second stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// ===== logic/gst_prescaler.sv
// selectable 1/2/4/8 divider of the counting tick
`timescale 1ns/1ps
module gst_prescaler (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	input wire logic tick_i,
	input wire logic [1:0] select_i,
	output logic tick_o
);
	logic [2:0] count_q;
	logic [2:0] last;

	// last count value before a tick passes
	always_comb begin
		unique case (select_i)
			2'h0: last = 3'h0;
			2'h1: last = 3'h1;
			2'h2: last = 3'h3;
			2'h3: last = 3'h7;
		endcase
	end

	// hidden from software; a counter write clears it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= 3'h0;
		end else if (clear_i) begin
			count_q <= 3'h0;
		end else if (tick_i) begin
			count_q <= (count_q >= last) ? 3'h0 : count_q + 3'h1;
		end
	end

	assign tick_o = tick_i && (count_q >= last);
endmodule

// ===== logic/gst_timer.sv
// gated sixteen bit timer with prescaler, gate, overflow flag and capture/compare base
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
//
// Behaviour
// R01: reads of either count byte return a coherent value in external async mode.
// R02: software should stop the timer before writing count bytes.
// R03: gate source selectable from gate pin, alternate pin or comparator output.
// R04: gate enable ignored when off; when on, count only while gate active.
// R05: gate polarity applies to any source; 1 high-active, 0 low-active.
// R06: count wraps from all-ones to zero and sets the overflow flag.
// R07: overflow interrupt needs overflow, peripheral and global enables all set.
// R08: overflow flag stays set until software writes zero to it.
// R09: software clears both count bytes and the flag before enabling interrupts.
// R10: in sleep, only async external counting runs; wake needs on and enables.
// R11: after wake, continue; with global enable, vector to fixed address.
// R12: capture copies the 16-bit count into the capture pair on an event.
// R13: compare raises an event when the pair equals the count.
// R14: special trigger clears the count without setting the overflow flag.
// R15: a count write in the same cycle as a special trigger wins.
// R16: software should use synchronized counting with the special trigger.
// R17: external counting needs a falling edge before the first counted rising edge.
// R18: prescale field divides by 1, 2, 4 or 8.
// R19: low-power oscillator enable counts only in internal-oscillator-without-clockout mode.
// R20: sync bit bypasses external input synchronization; ignored on internal clock.
// R21: clock source bit picks external pin, else instruction or system clock.
// R22: timer-on enables counting; off holds the count.
// R23: a write to either count byte loads the running counter directly.
// R24: prescale counter is hidden and cleared by any count byte write.
// R25: each qualified prescaler tick increments; low byte carries into high byte.
module gst_timer (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire gst_pkg::gst_pins_t pins_i,
	output logic irq_o,
	output logic wake_o,
	output logic [15:0] irq_vector_o,
	output logic compare_event_o,
	output logic lowpower_osc_on_o
);
	logic rst_meta_q;
	logic rst_sync_q;
	gst_pkg::gst_pins_t pins_s;
	gst_pkg::gst_control_t control_q;
	gst_pkg::gst_gate_config_t gate_config_q;
	logic [7:0] irq_enables_q;
	logic [7:0] cc_mode_q;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [15:0] cc_q;
	logic overflow_flag_q;
	logic [1:0] instr_div_q;
	logic ext_stage_q;
	logic ext_prev_q;
	logic armed_q;
	logic capture_prev_q;
	logic match_prev_q;
	logic [7:0] rdata_q;
	logic ext_source;
	logic ext_level;
	logic ext_rise;
	logic ext_fall;
	logic internal_tick;
	logic raw_tick;
	logic pre_tick;
	logic gate_level;
	logic gate_active;
	logic sleep_allows;
	logic count_enable;
	logic count_write;
	logic wrap;
	logic match;
	logic special_clear;
	logic flag_clear;
	logic lp_osc_on;

	// reset asserts at once and releases after two clean edges
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// every outside pin passes two flops before any logic looks at it
	gst_sync #(
		.WIDTH($bits(gst_pkg::gst_pins_t))
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_sync_q),
		.async_i(pins_i),
		.sync_o(pins_s)
	);

	assign count_write = wr_i && (addr_i == gst_pkg::ADDR_COUNT_LOW || addr_i == gst_pkg::ADDR_COUNT_HIGH);
	assign flag_clear = wr_i && addr_i == gst_pkg::ADDR_PERIPHERAL_FLAGS && !wdata_i[gst_pkg::FLAG_OVERFLOW_BIT];

	// timer control: every bit is software owned
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			control_q <= gst_pkg::TIMER_CONTROL_RESET;
		end else if (wr_i && addr_i == gst_pkg::ADDR_TIMER_CONTROL) begin
			control_q <= wdata_i;
		end
	end

	// gate configuration; upper bits kept at zero so they read back as zero
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			gate_config_q <= gst_pkg::GATE_CONFIG_RESET;
		end else if (wr_i && addr_i == gst_pkg::ADDR_GATE_CONFIG) begin
			gate_config_q <= {5'h00, wdata_i[2:0]};
		end
	end

	// overflow, peripheral and global interrupt enables
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			irq_enables_q <= gst_pkg::IRQ_ENABLES_RESET;
		end else if (wr_i && addr_i == gst_pkg::ADDR_IRQ_ENABLES) begin
			irq_enables_q <= {5'h00, wdata_i[2:0]};
		end
	end

	// capture, compare and special trigger mode bits
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			cc_mode_q <= gst_pkg::CC_MODE_RESET;
		end else if (wr_i && addr_i == gst_pkg::ADDR_CC_MODE) begin
			cc_mode_q <= {5'h00, wdata_i[2:0]};
		end
	end

	// the low-power oscillator only exists in one system clock mode
	assign lp_osc_on = control_q.lowpower_osc_enable && pins_s.internal_oscillator_no_clock_out_pin; // see R19
	assign ext_source = lp_osc_on ? pins_s.lowpower_osc_clock : pins_s.external_clock_pin;

	// synchronized mode adds a stage aligned to the system clock; bypass skips it
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ext_stage_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_stage_q <= ext_source;
			ext_prev_q <= ext_level;
		end
	end

	assign ext_level = control_q.sync_bypass ? ext_source : ext_stage_q; // see R20
	assign ext_rise = ext_level && !ext_prev_q;
	assign ext_fall = !ext_level && ext_prev_q;

	// a falling edge must arm the counter before a rising edge counts
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			armed_q <= 1'b0;
		end else if (!control_q.timer_on || count_write) begin
			armed_q <= 1'b0; // see R17
		end else if (ext_fall) begin
			armed_q <= 1'b1; // see R17
		end
	end

	// instruction clock is every fourth system clock
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			instr_div_q <= 2'h0;
		end else begin
			instr_div_q <= instr_div_q + 2'h1;
		end
	end

	assign internal_tick = gate_config_q.alternate_clock_select || instr_div_q == gst_pkg::INSTR_DIV_LAST;
	// external pin rising edge, or the internal clock selection
	assign raw_tick = control_q.clock_source_select ? (ext_rise && armed_q) : internal_tick; // see R21

	gst_prescaler u_prescaler (
		.clk_i(clk_i),
		.rst_n_i(rst_sync_q),
		.clear_i(count_write), // see R24
		.tick_i(raw_tick && control_q.timer_on),
		.select_i(control_q.prescale_select), // see R18
		.tick_o(pre_tick)
	);

	// gate source and polarity
	always_comb begin
		unique case (gate_config_q.gate_source_select) // see R03
			gst_pkg::GATE_SRC_PIN: gate_level = pins_s.gate_pin;
			gst_pkg::GATE_SRC_ALT_PIN: gate_level = pins_s.gate_pin_alt;
			gst_pkg::GATE_SRC_COMPARATOR: gate_level = pins_s.comparator_output;
			default: gate_level = pins_s.gate_pin;
		endcase
	end

	assign gate_active = control_q.gate_polarity ? gate_level : !gate_level; // see R05
	// while asleep only asynchronous external counting keeps running
	assign sleep_allows = !pins_s.sleep || (control_q.clock_source_select && control_q.sync_bypass); // see R10
	assign count_enable = control_q.timer_on && (!control_q.gate_enable || gate_active) && sleep_allows; // see R04
	assign wrap = pre_tick && count_enable && count_q == gst_pkg::COUNT_ALL_ONES; // see R06
	assign match = count_q == cc_q;
	assign special_clear = cc_mode_q[gst_pkg::CC_COMPARE_BIT] && cc_mode_q[gst_pkg::CC_SPECIAL_BIT] &&
		match && !match_prev_q; // see R14

	// next count: write beats trigger clear, which beats increment
	always_comb begin
		count_d = count_q;
		if (wr_i && addr_i == gst_pkg::ADDR_COUNT_LOW) begin
			count_d = {count_q[15:8], wdata_i}; // see R23
		end else if (wr_i && addr_i == gst_pkg::ADDR_COUNT_HIGH) begin
			count_d = {wdata_i, count_q[7:0]}; // see R23
		end else if (special_clear) begin
			count_d = gst_pkg::COUNT_RESET; // see R15
		end else if (pre_tick && count_enable) begin
			count_d = count_q + 16'h0001; // see R25
		end
	end

	// off holds the value since no tick is qualified
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			count_q <= gst_pkg::COUNT_RESET;
		end else begin
			count_q <= count_d; // see R22
		end
	end

	// overflow flag: hardware set wins over a software clear
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			overflow_flag_q <= 1'b0;
		end else if (wrap && !special_clear) begin
			overflow_flag_q <= 1'b1; // see R06
		end else if (flag_clear) begin
			overflow_flag_q <= 1'b0; // see R08
		end
	end

	// previous capture level, so a held event captures only once
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			capture_prev_q <= 1'b0;
		end else begin
			capture_prev_q <= pins_s.capture_event;
		end
	end

	// capture pair: captured count beats a software write in the same cycle
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			cc_q <= gst_pkg::CC_RESET;
		end else if (cc_mode_q[gst_pkg::CC_CAPTURE_BIT] && pins_s.capture_event && !capture_prev_q) begin
			cc_q <= count_q; // see R12
		end else if (wr_i && addr_i == gst_pkg::ADDR_CC_LOW) begin
			cc_q <= {cc_q[15:8], wdata_i};
		end else if (wr_i && addr_i == gst_pkg::ADDR_CC_HIGH) begin
			cc_q <= {wdata_i, cc_q[7:0]};
		end
	end

	// previous match level; a stopped timer sitting on the pair must not retrigger
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			match_prev_q <= 1'b0;
		end else begin
			match_prev_q <= match;
		end
	end

	// compare event fires once when the count first equals the pair
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			compare_event_o <= 1'b0;
		end else begin
			compare_event_o <= cc_mode_q[gst_pkg::CC_COMPARE_BIT] && match && !match_prev_q; // see R13
		end
	end

	// interrupt request needs all three enables beside the flag
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= overflow_flag_q && irq_enables_q[gst_pkg::EN_OVERFLOW_BIT] &&
				irq_enables_q[gst_pkg::EN_PERIPHERAL_BIT] && irq_enables_q[gst_pkg::EN_GLOBAL_BIT]; // see R07
		end
	end

	// wake request; the global enable only decides whether the core vectors afterwards
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			wake_o <= 1'b0;
		end else begin
			wake_o <= pins_s.sleep && overflow_flag_q && control_q.timer_on &&
				irq_enables_q[gst_pkg::EN_OVERFLOW_BIT] && irq_enables_q[gst_pkg::EN_PERIPHERAL_BIT]; // see R10
		end
	end

	// fixed vector, zero only while reset is held
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			irq_vector_o <= gst_pkg::COUNT_RESET;
		end else begin
			irq_vector_o <= gst_pkg::IRQ_VECTOR; // see R11
		end
	end

	// oscillator request as seen by the clock generator
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			lowpower_osc_on_o <= 1'b0;
		end else begin
			lowpower_osc_on_o <= lp_osc_on; // see R19
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rdata_q <= 8'h00;
		end else if (rd_i) begin
			unique case (addr_i)
				// each byte comes from the live counter flop, so it is never torn
				gst_pkg::ADDR_COUNT_LOW: rdata_q <= count_q[7:0]; // see R01
				gst_pkg::ADDR_COUNT_HIGH: rdata_q <= count_q[15:8]; // see R01
				gst_pkg::ADDR_TIMER_CONTROL: rdata_q <= control_q;
				gst_pkg::ADDR_GATE_CONFIG: rdata_q <= gate_config_q;
				gst_pkg::ADDR_PERIPHERAL_FLAGS: rdata_q <= {7'h00, overflow_flag_q};
				gst_pkg::ADDR_IRQ_ENABLES: rdata_q <= irq_enables_q;
				gst_pkg::ADDR_CC_LOW: rdata_q <= cc_q[7:0];
				gst_pkg::ADDR_CC_HIGH: rdata_q <= cc_q[15:8];
				gst_pkg::ADDR_CC_MODE: rdata_q <= cc_mode_q;
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata_o = rdata_q;
endmodule

// ===== test/gst_timer_monitor.sv
// port checker for the gated sixteen bit timer
`timescale 1ns/1ps
module gst_timer_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic irq_o,
	input wire logic wake_o,
	input wire logic [15:0] irq_vector_o,
	input wire logic compare_event_o,
	input wire logic lowpower_osc_on_o
);
	logic [7:0] ctl_q;
	logic [2:0] en_q;
	logic mode_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// shadow of written bits, so each output can be traced to its cause
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl_q <= 8'h00;
			en_q <= 3'h0;
			mode_q <= 1'b0;
		end else if (wr_i) begin
			if (addr_i == gst_pkg::ADDR_TIMER_CONTROL) ctl_q <= wdata_i;
			if (addr_i == gst_pkg::ADDR_IRQ_ENABLES) en_q <= wdata_i[2:0];
			if (addr_i == gst_pkg::ADDR_CC_MODE) mode_q <= wdata_i[1];
		end
	end
	a_vector_fixed: assert property ($past(rst_n_i, 3) && $past(rst_n_i, 2) && $past(rst_n_i)
		|-> irq_vector_o == gst_pkg::IRQ_VECTOR) else $error("bad vector");
	a_irq_enables: assert property (irq_o |-> &$past(en_q)) else $error("irq without enables");
	a_wake_enables: assert property (wake_o |-> $past(ctl_q[0]) && &$past(en_q[1:0]))
		else $error("wake without enables");
	a_osc_control: assert property (lowpower_osc_on_o |-> $past(ctl_q[3])) else $error("osc without enable");
	a_cmp_pulse: assert property (compare_event_o |=> !compare_event_o) else $error("long compare pulse");
	a_cmp_mode: assert property (compare_event_o |-> $past(mode_q)) else $error("compare outside mode");
	a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("stray read data");
	a_ctl_readback: assert property ($past(rd_i) && $past(addr_i) == gst_pkg::ADDR_TIMER_CONTROL
		|-> rdata_o == $past(ctl_q)) else $error("control readback");
endmodule
bind gst_timer gst_timer_monitor mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .wake_o(wake_o), .irq_vector_o(irq_vector_o),
	.compare_event_o(compare_event_o), .lowpower_osc_on_o(lowpower_osc_on_o));

// ===== test/gst_pins_model.sv
// far side: counting clock, gate sources, capture and sleep levels
`timescale 1ns/1ps
module gst_pins_model (
	input wire logic clk_i,
	input wire logic [1:0] gate_src_i,
	input wire logic gate_lvl_i,
	input wire logic ext_run_i,
	input wire logic cap_i,
	input wire logic sleep_i,
	input wire logic internal_oscillator_i,
	output gst_pkg::gst_pins_t pins_o
);
	logic ext_q = 1'b0;
	logic [2:0] ph_q = 3'h0;
	// ten clocks a period, still and low between runs
	always @(posedge clk_i) begin
		if (!ext_run_i) begin
			ext_q <= 1'b0;
			ph_q <= 3'h0;
		end else begin
			ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
			if (ph_q == 3'h4) ext_q <= ~ext_q;
		end
	end
	// unselected gate sources show the inverse, so a wrong pick is caught
	always_comb begin
		pins_o.external_clock_pin = ext_q;
		pins_o.lowpower_osc_clock = 1'b0;
		pins_o.gate_pin = (gate_src_i == gst_pkg::GATE_SRC_PIN) ? gate_lvl_i : ~gate_lvl_i;
		pins_o.gate_pin_alt = (gate_src_i == gst_pkg::GATE_SRC_ALT_PIN) ? gate_lvl_i : ~gate_lvl_i;
		pins_o.comparator_output = (gate_src_i == gst_pkg::GATE_SRC_COMPARATOR) ? gate_lvl_i : ~gate_lvl_i;
		pins_o.capture_event = cap_i;
		pins_o.sleep = sleep_i;
		pins_o.internal_oscillator_no_clock_out_pin = internal_oscillator_i;
	end
endmodule

// ===== test/gst_timer_test.sv
// self-checking bench for the gated sixteen bit timer
`timescale 1ns/1ps
module gst_timer_test;
	logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic gate_lvl = 1'b0, ext_run = 1'b0, cap = 1'b0, sleep = 1'b0, internal_oscillator = 1'b1;
	logic [1:0] gate_src = 2'h0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00, v, d;
	logic irq_o, wake_o, compare_event_o, lowpower_osc_on_o;
	logic [7:0] rdata_o;
	logic [15:0] irq_vector_o;
	gst_pkg::gst_pins_t pins_i;
	int fail_count = 0, n_tests = 0, cyc = 0;

	gst_timer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .pins_i(pins_i), .irq_o(irq_o), .wake_o(wake_o), .irq_vector_o(irq_vector_o),
		.compare_event_o(compare_event_o), .lowpower_osc_on_o(lowpower_osc_on_o));
	gst_pins_model far (.clk_i(clk_i), .gate_src_i(gate_src), .gate_lvl_i(gate_lvl), .ext_run_i(ext_run),
		.cap_i(cap), .sleep_i(sleep), .internal_oscillator_i(internal_oscillator), .pins_o(pins_i));

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task complete_run;
		if (fail_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// register port cycles, strobes one clock wide
	task wr(input logic [3:0] a, input logic [7:0] x);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= x;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] x);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		x = rdata_o;
	endtask
	task rc(input logic [3:0] a, input logic [7:0] e);
		rd(a, v);
		chk(v, e);
	endtask
	// low byte advance over exactly forty clocks
	task span(output logic [7:0] x);
		logic [7:0] a;
		rd(gst_pkg::ADDR_COUNT_LOW, a);
		repeat (38) @(posedge clk_i);
		rd(gst_pkg::ADDR_COUNT_LOW, x);
		x = x - a;
	endtask
	// bounded wait for irq, or a compare pulse when sel is set
	task wait_hi(input logic sel);
		int i;
		i = 0;
		do begin
			@(negedge clk_i);
			i++;
		end while ((sel ? compare_event_o : irq_o) !== 1'b1 && i < 200);
		chk(sel ? compare_event_o : irq_o, 1'b1);
	endtask
	// load with the timer stopped, then run the counting clock
	task ext_count(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ctl);
		wr(gst_pkg::ADDR_COUNT_HIGH, hi);
		wr(gst_pkg::ADDR_COUNT_LOW, lo);
		wr(gst_pkg::ADDR_TIMER_CONTROL, ctl);
		ext_run <= 1'b1;
		repeat (98) @(posedge clk_i);
		ext_run <= 1'b0;
		repeat (10) @(negedge clk_i);
	endtask

	task t_regs;
		rc(gst_pkg::ADDR_TIMER_CONTROL, gst_pkg::TIMER_CONTROL_RESET);
		rc(gst_pkg::ADDR_COUNT_HIGH, 8'h00);
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'hA8);
		rc(gst_pkg::ADDR_TIMER_CONTROL, 8'hA8);
		chk(lowpower_osc_on_o, 1'b1);
		@(posedge clk_i);
		internal_oscillator <= 1'b0;
		repeat (4) @(negedge clk_i);
		chk(lowpower_osc_on_o, 1'b0);
		@(posedge clk_i);
		internal_oscillator <= 1'b1;
		wr(4'hF, 8'hFF);
		rc(4'hF, 8'h00);
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h00);
	endtask
	task t_prescale;
		wr(gst_pkg::ADDR_GATE_CONFIG, 8'h04);
		for (int p = 0; p < 4; p++) begin
			wr(gst_pkg::ADDR_COUNT_LOW, 8'h00);
			wr(gst_pkg::ADDR_TIMER_CONTROL, {2'h0, p[1:0], 4'h1});
			span(d);
			chk(d, 8'h28 >> p);
		end
		// instruction clock: one tick every fourth system clock
		wr(gst_pkg::ADDR_GATE_CONFIG, 8'h00);
		wr(gst_pkg::ADDR_COUNT_LOW, 8'h00);
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h01);
		span(d);
		chk(d, 8'h0A);
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h00);
		span(d);
		chk(d, 8'h00);
	endtask
	task t_gate;
		for (int s = 0; s < 3; s++) begin
			for (int g = 0; g < 2; g++) begin
				wr(gst_pkg::ADDR_GATE_CONFIG, {6'h01, s[1:0]});
				gate_src <= s[1:0];
				gate_lvl <= ~g[0];
				wr(gst_pkg::ADDR_TIMER_CONTROL, {g[0], 7'h41});
				repeat (8) @(posedge clk_i);
				span(d);
				chk(d, 8'h00);
				@(posedge clk_i);
				gate_lvl <= g[0];
				repeat (8) @(posedge clk_i);
				span(d);
				chk(d, 8'h28);
			end
		end
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h00);
	endtask
	task t_overflow;
		wr(gst_pkg::ADDR_COUNT_HIGH, 8'h00);
		wr(gst_pkg::ADDR_COUNT_LOW, 8'h00);
		wr(gst_pkg::ADDR_PERIPHERAL_FLAGS, 8'h00);
		wr(gst_pkg::ADDR_IRQ_ENABLES, 8'h07);
		wr(gst_pkg::ADDR_COUNT_HIGH, 8'hFF);
		wr(gst_pkg::ADDR_COUNT_LOW, 8'hFE);
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h01);
		wait_hi(1'b0);
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h00);
		rc(gst_pkg::ADDR_COUNT_HIGH, 8'h00);
		rc(gst_pkg::ADDR_PERIPHERAL_FLAGS, 8'h01);
		wr(gst_pkg::ADDR_IRQ_ENABLES, 8'h03);
		repeat (2) @(negedge clk_i);
		chk(irq_o, 1'b0);
		wr(gst_pkg::ADDR_PERIPHERAL_FLAGS, 8'h01);
		wr(gst_pkg::ADDR_IRQ_ENABLES, 8'h07);
		repeat (2) @(negedge clk_i);
		chk(irq_o, 1'b1);
		wr(gst_pkg::ADDR_PERIPHERAL_FLAGS, 8'h00);
		repeat (2) @(negedge clk_i);
		chk(irq_o, 1'b0);
		wr(gst_pkg::ADDR_IRQ_ENABLES, 8'h00);
	endtask
	task t_special;
		wr(gst_pkg::ADDR_CC_LOW, 8'h10);
		wr(gst_pkg::ADDR_CC_MODE, 8'h06);
		wr(gst_pkg::ADDR_COUNT_LOW, 8'h00);
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h01);
		repeat (3) wait_hi(1'b1);
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h00);
		rd(gst_pkg::ADDR_COUNT_LOW, v);
		chk(v > 8'h10, 1'b0);
		rc(gst_pkg::ADDR_PERIPHERAL_FLAGS, 8'h00);
		// period of all ones: the clear must keep the wrap from setting the flag
		wr(gst_pkg::ADDR_CC_HIGH, 8'hFF);
		wr(gst_pkg::ADDR_CC_LOW, 8'hFF);
		wr(gst_pkg::ADDR_COUNT_HIGH, 8'hFF);
		wr(gst_pkg::ADDR_COUNT_LOW, 8'hF0);
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h01);
		wait_hi(1'b1);
		wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h00);
		rc(gst_pkg::ADDR_PERIPHERAL_FLAGS, 8'h00);
		rc(gst_pkg::ADDR_COUNT_HIGH, 8'h00);
	endtask
	task t_capture;
		wr(gst_pkg::ADDR_COUNT_HIGH, 8'h12);
		wr(gst_pkg::ADDR_COUNT_LOW, 8'h34);
		wr(gst_pkg::ADDR_CC_MODE, 8'h01);
		cap <= 1'b1;
		repeat (6) @(posedge clk_i);
		cap <= 1'b0;
		rc(gst_pkg::ADDR_COUNT_LOW, 8'h34);
		rc(gst_pkg::ADDR_CC_LOW, 8'h34);
		rc(gst_pkg::ADDR_CC_HIGH, 8'h12);
	endtask
	task t_external;
		for (int s = 0; s < 2; s++) begin
			ext_count(8'h00, 8'h00, {5'h00, s[0], 2'h3});
			rc(gst_pkg::ADDR_COUNT_LOW, 8'h09);
			wr(gst_pkg::ADDR_TIMER_CONTROL, 8'h00);
		end
		wr(gst_pkg::ADDR_IRQ_ENABLES, 8'h03);
		sleep <= 1'b1;
		ext_count(8'hFF, 8'hF8, 8'h07);
		chk(wake_o, 1'b1);
		chk(irq_o, 1'b0);
	endtask

	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// ceiling far above the fewer than two thousand cycles the scenarios need
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_regs();
		t_prescale();
		t_gate();
		t_overflow();
		t_special();
		t_capture();
		t_external();
		complete_run();
	end
endmodule
